//--- common/adsc_cfg.svh
// Offsets, field positions, reset values and timing counts for the activity/self-test block
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADSC_OFS_AXIS_CFG 7'h38
`define ADSC_OFS_THR_HI 7'h39
`define ADSC_OFS_THR_LO 7'h3A
`define ADSC_OFS_DUR_HI 7'h3B
`define ADSC_OFS_DUR_MID 7'h3C
`define ADSC_OFS_DUR_LO 7'h3D
`define ADSC_OFS_ACT_CTL 7'h37

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define ADSC_BIT_SELFTEST_MODE_EN 7
`define ADSC_BIT_SELFTEST_FORCE_EN 6
`define ADSC_BIT_SELFTEST_FORCE_INVERT 5
`define ADSC_AXIS_CFG_WMASK 8'hE7
`define ADSC_THR_HI_WMASK 8'h07
`define ADSC_ACT_EN_WMASK 8'h03
`define ADSC_REG_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing: one duration unit is 500 us, clock 40 MHz
// ----------------------------------------------------------------------------
`define ADSC_DUR_UNIT_NS 500000
`define ADSC_CLK_PERIOD_NS 25
`define ADSC_DUR_UNIT_CYC (`ADSC_DUR_UNIT_NS / `ADSC_CLK_PERIOD_NS)

`endif

//--- common/adsc_pkg.sv
// Types shared by the activity/self-test block
`default_nettype none
package adsc_pkg;
    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } adsc_req_type;

    // Activity-enable codes
    typedef enum logic [1:0] {
        ADSC_ACT_OFF  = 2'b00,
        ADSC_ACT_ABS  = 2'b01,
        ADSC_ACT_OFF2 = 2'b10,
        ADSC_ACT_REF  = 2'b11
    } adsc_act_mode_type;

    // Detector states
    typedef enum logic [1:0] {
        ADSC_ST_IDLE  = 2'b00,
        ADSC_ST_TIME  = 2'b01,
        ADSC_ST_FIRED = 2'b10
    } adsc_state_type;
endpackage
`default_nettype wire

//--- design/adsc_activity_cfg.sv
// Activity detector and self-test configuration block with its register file
//
// Notes on behaviour
// - Config bit 7 enters self-test mode
// - Config bit 6 drives self-test force output
// - Config bit 5 inverts self-test force direction
// - Bits 2:0 gate X, Y, Z detection
// - Reserved bits read back as zero
// - Compare sample magnitude with 11-bit threshold
// - Sample scaled by 16 before comparing
// - Threshold from 0x39[2:0] and 0x3A
// - Threshold used in raw converter codes
// - 24-bit duration, 500 us units, high at 0x3B
// - Nonzero duration needs sustained exceeding motion
// - Any single enabled axis may qualify
// - All registers reset to zero
// - Activity enable codes 00/10 stop detector
// - Duration middle 0x3C, low 0x3D
`include "adsc_cfg.svh"
`default_nettype none

module adsc_activity_cfg
    import adsc_pkg::*;
#(
    parameter int UNIT_CYC = `ADSC_DUR_UNIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire adsc_req_type req,
    output logic [7:0] rdata_r,
    // Converter samples, one strobe per X/Y/Z set
    input wire logic sample_valid,
    input wire logic [11:0] sample_x,
    input wire logic [11:0] sample_y,
    input wire logic [11:0] sample_z,
    // Sensor and detector outputs
    output logic selftest_mode_en_r,
    output logic selftest_force_en_r,
    output logic selftest_force_invert_r,
    output logic activity_event_r,
    output logic activity_active_r
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    logic [7:0] axis_cfg_r;
    logic [7:0] thr_hi_r;
    logic [7:0] thr_lo_r;
    logic [7:0] dur_hi_r;
    logic [7:0] dur_mid_r;
    logic [7:0] dur_lo_r;
    logic [7:0] act_ctl_r;
    logic [2:0] detect_axis_mask;
    logic [10:0] activity_threshold;
    logic [23:0] duration;
    logic detect_on;

    // Writes; read-only bits are masked so they can never be stored
    always_ff @(posedge clk) begin
        if (reset) begin
            axis_cfg_r <= `ADSC_REG_RESET;
            thr_hi_r <= `ADSC_REG_RESET;
            thr_lo_r <= `ADSC_REG_RESET;
            dur_hi_r <= `ADSC_REG_RESET;
            dur_mid_r <= `ADSC_REG_RESET;
            dur_lo_r <= `ADSC_REG_RESET;
            act_ctl_r <= `ADSC_REG_RESET;
        end else if (req.wr) begin
            case (req.addr)
                `ADSC_OFS_AXIS_CFG: axis_cfg_r <= req.wdata & `ADSC_AXIS_CFG_WMASK;
                `ADSC_OFS_THR_HI: thr_hi_r <= req.wdata & `ADSC_THR_HI_WMASK;
                `ADSC_OFS_THR_LO: thr_lo_r <= req.wdata;
                `ADSC_OFS_DUR_HI: dur_hi_r <= req.wdata;
                `ADSC_OFS_DUR_MID: dur_mid_r <= req.wdata;
                `ADSC_OFS_DUR_LO: dur_lo_r <= req.wdata;
                `ADSC_OFS_ACT_CTL: act_ctl_r <= req.wdata & `ADSC_ACT_EN_WMASK;
                default: ;
            endcase
        end
    end

    // Registered read data; unmapped offsets read zero
    // The host sees the answer one edge after the request, never in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `ADSC_OFS_AXIS_CFG: rdata_r <= axis_cfg_r;
                `ADSC_OFS_THR_HI: rdata_r <= thr_hi_r;
                `ADSC_OFS_THR_LO: rdata_r <= thr_lo_r;
                `ADSC_OFS_DUR_HI: rdata_r <= dur_hi_r;
                `ADSC_OFS_DUR_MID: rdata_r <= dur_mid_r;
                `ADSC_OFS_DUR_LO: rdata_r <= dur_lo_r;
                `ADSC_OFS_ACT_CTL: rdata_r <= act_ctl_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Self-test controls
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            selftest_mode_en_r <= 1'b0;
            selftest_force_en_r <= 1'b0;
            selftest_force_invert_r <= 1'b0;
        end else begin
            selftest_mode_en_r <= axis_cfg_r[`ADSC_BIT_SELFTEST_MODE_EN];
            selftest_force_en_r <= axis_cfg_r[`ADSC_BIT_SELFTEST_FORCE_EN];
            selftest_force_invert_r <= axis_cfg_r[`ADSC_BIT_SELFTEST_FORCE_INVERT];
        end
    end

    // ------------------------------------------------------------------------
    // Comparison path
    // ------------------------------------------------------------------------
    // axis gating field
    assign detect_axis_mask = axis_cfg_r[2:0];
    // threshold assembly, raw codes so no range rescale
    assign activity_threshold = {thr_hi_r[2:0], thr_lo_r};
    assign duration = {dur_hi_r, dur_mid_r, dur_lo_r};
    // only codes 01 and 11 run the detector
    // Bit 0 alone decides, so code 10 behaves exactly like 00;
    // referenced mode runs the same path as absolute mode here
    assign detect_on = act_ctl_r[0];

    // Magnitude of a signed sample, scaled by 16
    // The most negative code has no positive twin in 12 bits, but its
    // pattern read as unsigned is still the right magnitude, so no extra bit
    function automatic logic [15:0] scaled_mag(input logic [11:0] s);
        logic [11:0] m;
        m = s[11] ? 12'(-s) : s;
        scaled_mag = {m, 4'h0};
    endfunction

    logic [2:0] over;
    logic any_over;
    assign over[0] = scaled_mag(sample_x) > {5'h00, activity_threshold};
    assign over[1] = scaled_mag(sample_y) > {5'h00, activity_threshold};
    assign over[2] = scaled_mag(sample_z) > {5'h00, activity_threshold};
    assign any_over = |(over & detect_axis_mask);

    // ------------------------------------------------------------------------
    // Duration timer: units of 500 us
    // ------------------------------------------------------------------------
    logic [$clog2(UNIT_CYC+1)-1:0] tick_cnt_r;
    logic [23:0] unit_cnt_r;
    adsc_state_type state_r;
    logic unit_tick;
    // Prescaler wraps once per duration unit; a small UNIT_CYC shortens
    // simulation, the default matches the real unit at this clock rate
    assign unit_tick = (tick_cnt_r == ($bits(tick_cnt_r))'(UNIT_CYC - 1));

    // Detector state; clearing the enable code drops everything at once

    always_ff @(posedge clk) begin
        if (reset || !detect_on) begin
            state_r <= ADSC_ST_IDLE;
            tick_cnt_r <= '0;
            unit_cnt_r <= 24'h000000;
            activity_event_r <= 1'b0;
            activity_active_r <= 1'b0;
        end else begin
            activity_event_r <= 1'b0;
            case (state_r)
                ADSC_ST_IDLE: begin
                    if (sample_valid && any_over) begin
                        if (duration == 24'h000000) begin
                            state_r <= ADSC_ST_FIRED;
                            activity_event_r <= 1'b1;
                            activity_active_r <= 1'b1;
                        end else begin
                            state_r <= ADSC_ST_TIME;
                            tick_cnt_r <= '0;
                            unit_cnt_r <= 24'h000000;
                        end
                    end
                end
                ADSC_ST_TIME: begin
                    if (sample_valid && !any_over) begin
                        state_r <= ADSC_ST_IDLE;
                    end else if (unit_tick) begin
                        tick_cnt_r <= '0;
                        if (unit_cnt_r + 24'h000001 >= duration) begin
                            state_r <= ADSC_ST_FIRED;
                            activity_event_r <= 1'b1;
                            activity_active_r <= 1'b1;
                        end else begin
                            unit_cnt_r <= unit_cnt_r + 24'h000001;
                        end
                    end else begin
                        tick_cnt_r <= tick_cnt_r + 1'b1;
                    end
                end
                ADSC_ST_FIRED: begin
                    // Re-arm once motion drops below threshold
                    // Without this a steady shake would raise an event every sample
                    if (sample_valid && !any_over) begin
                        state_r <= ADSC_ST_IDLE;
                        activity_active_r <= 1'b0;
                    end
                end
                default: state_r <= ADSC_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_selftest_mode_en_follow: assert property (@(posedge clk) disable iff (reset)
        req.wr && req.addr == `ADSC_OFS_AXIS_CFG |=> ##1
        selftest_mode_en_r == $past(req.wdata[7], 2))
        else $error("self-test mode does not follow config write");
    a_selftest_force_en_follow: assert property (@(posedge clk) disable iff (reset)
        ##1 selftest_force_en_r == $past(axis_cfg_r[6]))
        else $error("force output not tracking bit 6");
    a_selftest_force_invert_follow: assert property (@(posedge clk) disable iff (reset)
        ##1 selftest_force_invert_r == $past(axis_cfg_r[5]))
        else $error("direction output not tracking bit 5");
    a_resv_zero: assert property (@(posedge clk) disable iff (reset)
        axis_cfg_r[4:3] == 2'b00 && thr_hi_r[7:3] == 5'h00)
        else $error("reserved bits not zero");
    a_no_axis_quiet: assert property (@(posedge clk) disable iff (reset)
        detect_axis_mask == 3'b000 && state_r == ADSC_ST_IDLE |=> !activity_event_r)
        else $error("event with no axis enabled");
    a_off_no_event: assert property (@(posedge clk) disable iff (reset)
        !detect_on |=> !activity_event_r && state_r == ADSC_ST_IDLE)
        else $error("detector active while disabled");
    sequence s_fire_now;
        state_r == ADSC_ST_IDLE && sample_valid && any_over && duration == 24'h000000;
    endsequence
    a_zero_dur_fire: assert property (@(posedge clk) disable iff (reset)
        s_fire_now ##0 detect_on |=> activity_event_r)
        else $error("zero duration did not fire on first sample");
    a_quiet_restart: assert property (@(posedge clk) disable iff (reset)
        detect_on && state_r == ADSC_ST_TIME && sample_valid && !any_over
        |=> state_r == ADSC_ST_IDLE && !activity_event_r)
        else $error("quiet sample did not restart timer");
    a_reset_zero: assert property (@(posedge clk)
        $past(reset) |-> axis_cfg_r == 8'h00 && dur_hi_r == 8'h00 && thr_lo_r == 8'h00)
        else $error("register not zero after reset");

    // Self-test outputs come up clear after reset
    a_st_reset_clear: assert property (@(posedge clk)
        $past(reset) |-> !selftest_mode_en_r && !selftest_force_en_r && !selftest_force_invert_r)
        else $error("self-test output not clear after reset");

    // Event is a single-cycle pulse; the level carries the lasting state
    a_event_pulse: assert property (@(posedge clk) disable iff (reset)
        activity_event_r |=> !activity_event_r)
        else $error("activity event longer than one cycle");

    // The level may only rise together with the event pulse
    a_level_rise: assert property (@(posedge clk) disable iff (reset)
        $rose(activity_active_r) |-> activity_event_r)
        else $error("activity level rose without an event");

    // Timing in progress cannot fire between unit ticks
    a_no_early_fire: assert property (@(posedge clk) disable iff (reset)
        detect_on && state_r == ADSC_ST_TIME && !unit_tick |=> !activity_event_r)
        else $error("activity fired before a unit boundary");

    // Reserved bits read back as zero on the register port
    a_rd_resv_cfg: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr == `ADSC_OFS_AXIS_CFG |=> rdata_r[4:3] == 2'b00)
        else $error("reserved config bits read nonzero");
    a_rd_resv_thr: assert property (@(posedge clk) disable iff (reset)
        req.rd && req.addr == `ADSC_OFS_THR_HI |=> rdata_r[7:3] == 5'h00)
        else $error("reserved threshold bits read nonzero");

    // A lone enabled Y axis over threshold is enough to qualify
    sequence s_y_only;
        state_r == ADSC_ST_IDLE && sample_valid && detect_axis_mask == 3'b010 && over[1];
    endsequence
    a_one_axis_fire: assert property (@(posedge clk) disable iff (reset)
        s_y_only ##0 detect_on && duration == 24'h000000 |=> activity_event_r)
        else $error("single enabled axis did not qualify");

endmodule

`default_nettype wire

//--- dv/adsc_host_model.sv
// Host model that issues register reads and writes to the block
`default_nettype none

module adsc_host_model
    import adsc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output adsc_req_type req,
    input wire logic [7:0] rdata_r
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    initial req = '0;

    // One-cycle write pulse; the idle edge after it keeps calls apart
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask

    // Read data is registered, so it is taken one edge after the request
    task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        d = rdata_r;
    endtask
endmodule

`default_nettype wire

//--- dv/adsc_activity_cfg_test.sv
// Self-checking testbench for the activity detector and self-test block
`default_nettype none

module adsc_activity_cfg_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals, clock and instances
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    adsc_pkg::adsc_req_type req;
    logic [7:0] rdata_r;
    logic sample_valid = 1'b0;
    logic [11:0] sample_x = 12'h000;
    logic [11:0] sample_y = 12'h000;
    logic [11:0] sample_z = 12'h000;
    logic selftest_mode_en, selftest_force_en, st_inv, act_ev, act_lvl;
    int err_count = 0;
    int total_checks = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // Short duration unit keeps timed runs to a few cycles
    adsc_activity_cfg #(.UNIT_CYC(4)) u_adsc_activity_cfg (.clk(clk), .reset(reset),
        .req(req), .rdata_r(rdata_r), .sample_valid(sample_valid), .sample_x(sample_x),
        .sample_y(sample_y), .sample_z(sample_z), .selftest_mode_en_r(selftest_mode_en),
        .selftest_force_en_r(selftest_force_en), .selftest_force_invert_r(st_inv),
        .activity_event_r(act_ev), .activity_active_r(act_lvl));
    adsc_host_model u_adsc_host_model (.clk(clk), .req(req), .rdata_r(rdata_r));

    // Compare tasks: one for values, one for cycle counts
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("BAD t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_adsc_host_model.rd_reg(a, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_adsc_host_model.wr_reg(a, d);
    endtask

    // One sample set; event and level are both expected equal to exp
    task automatic hit(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z,
                       input logic exp);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_x <= x;
        sample_y <= y;
        sample_z <= z;
        @(posedge clk);
        sample_valid <= 1'b0;
        @(posedge clk);
        chk({6'h00, act_ev, act_lvl}, {6'h00, exp, exp});
    endtask

    // Back-to-back X samples; reports the cycle where the event shows
    task automatic stream(input logic [11:0] x, input int n, output int at);
        at = 0;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            sample_valid <= 1'b1;
            sample_x <= x;
            if (act_ev === 1'b1 && at == 0) at = i;
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int a = 'h37; a <= 'h3D; a++) rd_chk(7'(a), 8'h00);
        chk({5'h00, selftest_mode_en, selftest_force_en, st_inv}, 8'h00);
    endtask

    task automatic t_selftest();
        logic [7:0] wv[3] = '{8'hFF, 8'h20, 8'h80};
        logic [7:0] ev[3] = '{8'h07, 8'h01, 8'h04};
        wr(7'h38, 8'hFF);
        rd_chk(7'h38, 8'hE7);
        for (int i = 0; i < 3; i++) begin
            wr(7'h38, wv[i]);
            repeat (2) @(posedge clk);
            chk({5'h00, selftest_mode_en, selftest_force_en, st_inv}, ev[i]);
        end
    endtask

    task automatic t_regs();
        logic [6:0] a[6] = '{7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h50};
        logic [7:0] e[6] = '{8'h07, 8'h5A, 8'hC3, 8'h96, 8'h69, 8'h00};
        logic [7:0] w[6] = '{8'hFF, 8'h5A, 8'hC3, 8'h96, 8'h69, 8'hFF};
        for (int i = 0; i < 6; i++) wr(a[i], w[i]);
        for (int i = 0; i < 6; i++) rd_chk(a[i], e[i]);
        for (int i = 2; i < 5; i++) wr(a[i], 8'h00);
    endtask

    task automatic t_detect();
        wr(7'h37, 8'h01);
        wr(7'h38, 8'h01);
        wr(7'h39, 8'h00);
        wr(7'h3A, 8'h10);
        hit(12'h001, 12'h000, 12'h000, 1'b0);
        hit(12'h002, 12'h000, 12'h000, 1'b1);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        hit(12'hFFE, 12'h000, 12'h000, 1'b1);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        wr(7'h39, 8'h07);
        wr(7'h3A, 8'hFF);
        hit(12'h07F, 12'h000, 12'h000, 1'b0);
        hit(12'h080, 12'h000, 12'h000, 1'b1);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        wr(7'h38, 8'h02);
        hit(12'h7FF, 12'h000, 12'h7FF, 1'b0);
        hit(12'h000, 12'h080, 12'h000, 1'b1);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        wr(7'h38, 8'h04);
        hit(12'h000, 12'h000, 12'h080, 1'b1);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        wr(7'h38, 8'h00);
        hit(12'h7FF, 12'h7FF, 12'h7FF, 1'b0);
        wr(7'h38, 8'h07);
        wr(7'h37, 8'h02);
        hit(12'h7FF, 12'h000, 12'h000, 1'b0);
        wr(7'h37, 8'h03);
        hit(12'h7FF, 12'h000, 12'h000, 1'b1);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        wr(7'h37, 8'h00);
        hit(12'h7FF, 12'h000, 12'h000, 1'b0);
    endtask

    task automatic t_duration();
        int at;
        wr(7'h37, 8'h01);
        wr(7'h3D, 8'h01);
        stream(12'h7FF, 12, at);
        chk_rng(at, 5, 10);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        stream(12'h7FF, 2, at);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
        stream(12'h7FF, 12, at);
        chk_rng(at, 5, 10);
        hit(12'h000, 12'h000, 12'h000, 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_selftest();
        t_regs();
        t_detect();
        t_duration();
        final_report();
    end

    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #500us;
        err_count++;
        final_report();
    end
endmodule

`default_nettype wire
